// file: design/timer_block.sv
// Three-channel 16-bit timer with capture, clock control and triggers.
//
// Behaviour
// [RULE1]: 16-bit counter counts selected clock rising edges.
// [RULE2]: Wrap from all-ones sets overflow flag.
// [RULE3]: Trigger clears counter at next active edge.
// [RULE4]: Block mode routes pins or line A.
// [RULE5]: Clock select: five internal, three external.
// [RULE6]: Invert bit counts on opposite edge.
// [RULE7]: Gate counts only while chosen input high.
// [RULE8]: External clocks slow, levels above one period.
// [RULE9]: Enable/disable commands; disabled ignores start/stop.
// [RULE10]: B load or compare may disable clock.
// [RULE11]: Status shows clock enabled state.
// [RULE12]: Triggers start; B load or compare stop.
// [RULE13]: Waveform bit sets line directions.
// [RULE14]: Software trigger bit triggers channel.
// [RULE15]: Block sync write triggers all channels.
// [RULE16]: Counter equal compare C may trigger.
// [RULE17]: External trigger source per mode, enable bit.
// [RULE18]: Trigger pulses last over one period.
// [RULE19]: Edge field selects trigger edge; zero off.
// [RULE20]: Capture A and B latch on line A edges.
// [RULE21]: A and B load in alternating order.
// [RULE22]: Reload before read overwrites, sets overrun.
// [RULE23]: Event flags clear on status read.
// [RULE24]: Reset: counter zero, clock off, unloaded.
//
// The address map and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module timer_block (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [2:0] ext_clock_pin,
	input wire logic slow_clk_pin,
	input wire logic [2:0] line_a_in,
	output logic [2:0] line_a_out,
	output logic [2:0] line_a_oe,
	input wire logic [2:0] line_b_in,
	output logic [2:0] line_b_out,
	output logic [2:0] line_b_oe
);

	typedef struct packed {
		timer_pkg::channel_state_t [2:0] ch;
		logic [6:0] divider;
		logic [7:0] prev_source;
		logic [5:0] block_mode;
		logic ack;
		logic [31:0] rdata;
	} block_state_t;

	block_state_t state_ff;
	block_state_t nxt_state;

	logic [9:0] pins_sync;
	logic [2:0] ext_clock_in;
	logic [7:0] source_level;
	logic [7:0] source_rise;
	logic [7:0] source_fall;
	logic [2:0] line_a;
	logic [2:0] line_b;
	logic bus_request;
	logic bus_start;
	logic write_done;
	logic read_done;
	logic [1:0] addr_sel;
	logic [5:0] addr_word;

	// Edge field test: bit 0 asks for rising, bit 1 for falling.
	function automatic logic edge_hit(
		input logic [1:0] sel,
		input logic rise,
		input logic fall
	);
		edge_hit = (sel[timer_pkg::EDGE_RISE_BIT] & rise) |
			(sel[timer_pkg::EDGE_FALL_BIT] & fall);
	endfunction : edge_hit

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and clock sources.

	pin_sync #(
		.WIDTH(10)
	) u_pin_sync (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.async_in({slow_clk_pin, line_b_in, line_a_in, ext_clock_pin}),
		.sync_out(pins_sync)
	);

	assign line_a = pins_sync[5:3];
	assign line_b = pins_sync[8:6];

	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			case (state_ff.block_mode[2*i +: 2])
				timer_pkg::CHAIN_PIN:
					ext_clock_in[i] = pins_sync[i]; // [RULE4]
				timer_pkg::CHAIN_NEXT_LINE_A:
					ext_clock_in[i] = line_a[(i + 1) % 3]; // [RULE4]
				timer_pkg::CHAIN_PREV_LINE_A:
					ext_clock_in[i] = line_a[(i + 2) % 3]; // [RULE4]
				default:
					ext_clock_in[i] = 1'b0;
			endcase
		end
	end

	// Internal clocks are divider bits for /2, /8, /32, /128 plus the slow
	// clock, so an index equal to the clock select field picks the source.
	// External clocks are only seen through two flops, which is why they
	// must stay well below the system clock rate. [RULE8]
	assign source_level = {ext_clock_in, pins_sync[9], state_ff.divider[6],
		state_ff.divider[4], state_ff.divider[2], state_ff.divider[0]};
	assign source_rise = source_level & ~state_ff.prev_source;
	assign source_fall = ~source_level & state_ff.prev_source;

	////////////////////////////////////////////////////////////////////////
	// Avalon slave: every access is answered one cycle after it is seen.

	assign bus_request = avs_read | avs_write;
	assign bus_start = bus_request & ~state_ff.ack;
	assign write_done = avs_write & state_ff.ack;
	assign read_done = avs_read & state_ff.ack;
	assign addr_sel = avs_address[timer_pkg::SEL_MSB:timer_pkg::SEL_LSB];
	assign addr_word = avs_address[timer_pkg::SEL_LSB-1:0];
	assign avs_waitrequest = bus_request & ~state_ff.ack;
	assign avs_readdata = state_ff.rdata;

	////////////////////////////////////////////////////////////////////////
	// Channel and register logic.

	always_comb
	begin
		timer_pkg::channel_state_t cs;
		timer_pkg::channel_mode_t m;
		logic sync_all;
		logic chan_write;
		logic ccr_write;
		logic sel_clock;
		logic gate;
		logic tick;
		logic running;
		logic rise_a;
		logic fall_a;
		logic rise_b;
		logic fall_b;
		logic ext_rise;
		logic ext_fall;
		logic ext_trigger;
		logic compare;
		logic trigger;
		logic load_a;
		logic load_b;
		logic stop;
		logic disable_clk;
		logic read_status;
		logic [31:0] status;

		cs = '0;
		m = '0;
		sync_all = 1'b0;
		chan_write = 1'b0;
		ccr_write = 1'b0;
		sel_clock = 1'b0;
		gate = 1'b0;
		tick = 1'b0;
		running = 1'b0;
		rise_a = 1'b0;
		fall_a = 1'b0;
		rise_b = 1'b0;
		fall_b = 1'b0;
		ext_rise = 1'b0;
		ext_fall = 1'b0;
		ext_trigger = 1'b0;
		compare = 1'b0;
		trigger = 1'b0;
		load_a = 1'b0;
		load_b = 1'b0;
		stop = 1'b0;
		disable_clk = 1'b0;
		read_status = 1'b0;
		status = 32'h0000_0000;
		nxt_state = state_ff;
		nxt_state.divider = state_ff.divider + 7'h01;
		nxt_state.prev_source = source_level;
		nxt_state.ack = bus_start;
		nxt_state.rdata = state_ff.rdata;

		// One write to the block control word triggers every channel.
		sync_all = write_done && addr_sel == timer_pkg::SEL_BLOCK &&
			addr_word == timer_pkg::OFS_BLOCK_CONTROL &&
			avs_writedata[timer_pkg::BCR_SYNC]; // [RULE15]

		if (write_done && addr_sel == timer_pkg::SEL_BLOCK &&
			addr_word == timer_pkg::OFS_BLOCK_MODE)
			nxt_state.block_mode = avs_writedata[5:0];

		if (bus_start)
		begin
			nxt_state.rdata = 32'h0000_0000;
			if (addr_sel == timer_pkg::SEL_BLOCK &&
				addr_word == timer_pkg::OFS_BLOCK_MODE)
				nxt_state.rdata = {26'h0, state_ff.block_mode};
		end

		for (int c = 0; c < 3; c++)
		begin
			cs = state_ff.ch[c];
			m = cs.mode;
			chan_write = write_done && addr_sel == 2'(c);
			ccr_write = chan_write &&
				addr_word == timer_pkg::OFS_CHANNEL_CONTROL;

			// Clock path: select, invert, then gate. [RULE5] [RULE6]
			sel_clock = source_level[m.clock_select_field] ^
				m.clock_invert_bit;
			if (m.gate_select_field == timer_pkg::GATE_NONE)
				gate = 1'b1;
			else
				gate = ext_clock_in[2'(m.gate_select_field - 2'h1)]; // [RULE7]
			tick = sel_clock & ~cs.prev_clock & gate; // [RULE1]
			running = cs.clock_enabled & cs.clock_started;

			rise_a = line_a[c] & ~cs.prev_line_a;
			fall_a = ~line_a[c] & cs.prev_line_a;
			rise_b = line_b[c] & ~cs.prev_line_b;
			fall_b = ~line_b[c] & cs.prev_line_b;

			// External trigger source differs per mode. [RULE17]
			if (!m.waveform_bit)
			begin
				ext_rise = m.trigger_source_bit ? rise_a : rise_b;
				ext_fall = m.trigger_source_bit ? fall_a : fall_b;
			end
			else if (m.event_select_field == timer_pkg::EVT_LINE_B)
			begin
				ext_rise = rise_b;
				ext_fall = fall_b;
			end
			else
			begin
				ext_rise = source_rise[3'(m.event_select_field) + 3'h4];
				ext_fall = source_fall[3'(m.event_select_field) + 3'h4];
			end
			// Edges shorter than a system clock period may be missed. [RULE18]
			ext_trigger = edge_hit(m.ext_trigger_edge_field, ext_rise,
				ext_fall) & (~m.waveform_bit |
				m.event_trigger_enable_bit); // [RULE19] [RULE17]

			compare = tick & running &
				(cs.counter_value == cs.compare_reg_c);
			trigger = (ccr_write &&
				avs_writedata[timer_pkg::CCR_SOFTWARE_TRIGGER]) || // [RULE14]
				sync_all || ext_trigger || // [RULE15]
				(compare && m.rc_compare_trigger_bit); // [RULE16]

			// Capture loads alternate A then B. [RULE20] [RULE21]
			load_a = ~m.waveform_bit & ~cs.a_loaded &
				edge_hit(m.load_a_edge_field, rise_a, fall_a);
			load_b = ~m.waveform_bit & cs.a_loaded &
				edge_hit(m.load_b_edge_field, rise_a, fall_a);

			stop = (load_b & m.load_b_stops_bit) |
				(m.waveform_bit & compare & m.compare_stops_bit); // [RULE12]
			disable_clk = (load_b & m.load_b_disables_bit) |
				(m.waveform_bit & compare & m.compare_disables_bit) |
				(ccr_write &&
				avs_writedata[timer_pkg::CCR_CLOCK_DISABLE]); // [RULE10]

			cs.prev_clock = sel_clock;
			cs.prev_line_a = line_a[c];
			cs.prev_line_b = line_b[c];

			// Register writes.
			if (chan_write && addr_word == timer_pkg::OFS_CHANNEL_MODE)
				cs.mode = avs_writedata;
			if (chan_write && addr_word == timer_pkg::OFS_COMPARE_C)
				cs.compare_reg_c = avs_writedata[15:0];
			if (chan_write && m.waveform_bit &&
				addr_word == timer_pkg::OFS_CAPTURE_A)
				cs.capture_reg_a = avs_writedata[15:0];
			if (chan_write && m.waveform_bit &&
				addr_word == timer_pkg::OFS_CAPTURE_B)
				cs.capture_reg_b = avs_writedata[15:0];

			// Reads clear flags; only the bits returned are cleared, and
			// hardware sets below win over the clear. [RULE23]
			read_status = read_done && addr_sel == 2'(c) &&
				addr_word == timer_pkg::OFS_CHANNEL_STATUS;
			if (read_status)
			begin
				cs.counter_overflow_flag = cs.counter_overflow_flag &
					~state_ff.rdata[timer_pkg::SR_OVERFLOW];
				cs.load_overrun_flag = cs.load_overrun_flag &
					~state_ff.rdata[timer_pkg::SR_LOAD_OVERRUN];
			end
			if (read_done && addr_sel == 2'(c) &&
				addr_word == timer_pkg::OFS_CAPTURE_A)
				cs.a_unread = 1'b0;
			if (read_done && addr_sel == 2'(c) &&
				addr_word == timer_pkg::OFS_CAPTURE_B)
				cs.b_unread = 1'b0;

			// Enable and start control; disable wins over enable.
			if (ccr_write && avs_writedata[timer_pkg::CCR_CLOCK_ENABLE])
				cs.clock_enabled = 1'b1; // [RULE9]
			if (disable_clk)
				cs.clock_enabled = 1'b0; // [RULE9] [RULE10]
			if (state_ff.ch[c].clock_enabled)
			begin
				if (stop)
					cs.clock_started = 1'b0; // [RULE12]
				if (trigger)
					cs.clock_started = 1'b1; // [RULE12]
			end
			if (!cs.clock_enabled)
				cs.clock_started = 1'b0; // [RULE9]

			// The clear waits for the next active clock edge. [RULE3]
			if (tick && running)
			begin
				if (state_ff.ch[c].clear_pending)
					cs.counter_value = 16'h0000;
				else
				begin
					cs.counter_value = cs.counter_value + 16'h0001; // [RULE1]
					if (cs.counter_value == 16'h0000)
						cs.counter_overflow_flag = 1'b1; // [RULE2]
				end
				cs.clear_pending = trigger;
			end
			else if (trigger)
				cs.clear_pending = 1'b1; // [RULE3]

			if (trigger)
				cs.a_loaded = 1'b0; // [RULE21]
			if (load_a)
			begin
				cs.capture_reg_a = state_ff.ch[c].counter_value; // [RULE20]
				cs.a_loaded = 1'b1;
				if (state_ff.ch[c].a_unread)
					cs.load_overrun_flag = 1'b1; // [RULE22]
				cs.a_unread = 1'b1;
			end
			if (load_b)
			begin
				cs.capture_reg_b = state_ff.ch[c].counter_value; // [RULE20]
				cs.a_loaded = 1'b0; // [RULE21]
				if (state_ff.ch[c].b_unread)
					cs.load_overrun_flag = 1'b1; // [RULE22]
				cs.b_unread = 1'b1;
			end

			status = 32'h0000_0000;
			status[timer_pkg::SR_OVERFLOW] =
				state_ff.ch[c].counter_overflow_flag;
			status[timer_pkg::SR_LOAD_OVERRUN] =
				state_ff.ch[c].load_overrun_flag;
			status[timer_pkg::SR_CLOCK_ENABLED] =
				state_ff.ch[c].clock_enabled; // [RULE11]

			if (bus_start && addr_sel == 2'(c))
			begin
				case (addr_word)
					timer_pkg::OFS_CHANNEL_MODE:
						nxt_state.rdata = state_ff.ch[c].mode;
					timer_pkg::OFS_COUNTER_VALUE:
						nxt_state.rdata = {16'h0,
							state_ff.ch[c].counter_value};
					timer_pkg::OFS_CAPTURE_A:
						nxt_state.rdata = {16'h0,
							state_ff.ch[c].capture_reg_a};
					timer_pkg::OFS_CAPTURE_B:
						nxt_state.rdata = {16'h0,
							state_ff.ch[c].capture_reg_b};
					timer_pkg::OFS_COMPARE_C:
						nxt_state.rdata = {16'h0,
							state_ff.ch[c].compare_reg_c};
					timer_pkg::OFS_CHANNEL_STATUS:
						nxt_state.rdata = status;
					default:
						nxt_state.rdata = 32'h0000_0000;
				endcase
			end

			nxt_state.ch[c] = cs;
		end
	end

	// Reset leaves counters at zero, clocks disabled and stopped, and both
	// capture registers unloaded. [RULE24]
	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	////////////////////////////////////////////////////////////////////////
	// Line directions. The waveform output controller is not part of this
	// block, so driven lines carry a steady low level.

	always_comb
	begin
		for (int c = 0; c < 3; c++)
		begin
			line_a_oe[c] = state_ff.ch[c].mode.waveform_bit; // [RULE13]
			line_b_oe[c] = state_ff.ch[c].mode.waveform_bit &&
				state_ff.ch[c].mode.event_select_field !=
				timer_pkg::EVT_LINE_B; // [RULE13]
		end
	end

	assign line_a_out = 3'h0;
	assign line_b_out = 3'h0;

endmodule : timer_block

// file: design/timer_pkg.sv
// Package with register map, field layouts and encodings of the timer block.
package timer_pkg;

	localparam int CNT_W = 16;
	localparam logic [15:0] CNT_MAX = 16'hffff;

	// Byte address: bits 7:6 pick a channel (3 = block), bits 5:0 the word.
	localparam int SEL_MSB = 7;
	localparam int SEL_LSB = 6;
	localparam logic [1:0] SEL_BLOCK = 2'h3;

	localparam logic [5:0] OFS_CHANNEL_CONTROL = 6'h00;
	localparam logic [5:0] OFS_CHANNEL_MODE = 6'h04;
	localparam logic [5:0] OFS_COUNTER_VALUE = 6'h10;
	localparam logic [5:0] OFS_CAPTURE_A = 6'h14;
	localparam logic [5:0] OFS_CAPTURE_B = 6'h18;
	localparam logic [5:0] OFS_COMPARE_C = 6'h1c;
	localparam logic [5:0] OFS_CHANNEL_STATUS = 6'h20;
	localparam logic [5:0] OFS_BLOCK_CONTROL = 6'h00;
	localparam logic [5:0] OFS_BLOCK_MODE = 6'h04;

	localparam int CCR_CLOCK_ENABLE = 0;
	localparam int CCR_CLOCK_DISABLE = 1;
	localparam int CCR_SOFTWARE_TRIGGER = 2;
	localparam int BCR_SYNC = 0;
	localparam int SR_OVERFLOW = 0;
	localparam int SR_LOAD_OVERRUN = 1;
	localparam int SR_CLOCK_ENABLED = 16;

	localparam logic [31:0] MODE_RESET = 32'h0000_0000;
	localparam logic [5:0] BLOCK_MODE_RESET = 6'h00;

	// Edge fields: 0 none, 1 rising, 2 falling, 3 both.
	localparam int EDGE_RISE_BIT = 0;
	localparam int EDGE_FALL_BIT = 1;

	// Clock select 0..3 internal prescaled clocks, 4 the slow clock, 5..7 external clocks.
	localparam logic [2:0] CLK_SEL_EXT_0 = 3'h5;

	// Gate and event source: 0 none or line B, 1..3 external clock 0..2.
	localparam logic [1:0] EVT_LINE_B = 2'h0;
	localparam logic [1:0] GATE_NONE = 2'h0;

	// Block mode chain field per channel.
	localparam logic [1:0] CHAIN_PIN = 2'h0;
	localparam logic [1:0] CHAIN_NEXT_LINE_A = 2'h1;
	localparam logic [1:0] CHAIN_PREV_LINE_A = 2'h2;

	typedef struct packed {
		logic [6:0] reserved_hi;
		logic compare_disables_bit;
		logic compare_stops_bit;
		logic event_trigger_enable_bit;
		logic [1:0] event_select_field;
		logic [1:0] load_b_edge_field;
		logic [1:0] load_a_edge_field;
		logic waveform_bit;
		logic rc_compare_trigger_bit;
		logic [2:0] reserved_mid;
		logic trigger_source_bit;
		logic [1:0] ext_trigger_edge_field;
		logic load_b_disables_bit;
		logic load_b_stops_bit;
		logic [1:0] gate_select_field;
		logic clock_invert_bit;
		logic [2:0] clock_select_field;
	} channel_mode_t;

	typedef struct packed {
		logic [15:0] counter_value;
		logic [15:0] capture_reg_a;
		logic [15:0] capture_reg_b;
		logic [15:0] compare_reg_c;
		channel_mode_t mode;
		logic clock_enabled;
		logic clock_started;
		logic clear_pending;
		logic a_loaded;
		logic a_unread;
		logic b_unread;
		logic counter_overflow_flag;
		logic load_overrun_flag;
		logic prev_clock;
		logic prev_line_a;
		logic prev_line_b;
	} channel_state_t;

endpackage : timer_pkg

// file: design/pin_sync.sv
// Two-stage synchroniser for pins that arrive from outside the clock domain.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 10
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_state_t;

	sync_state_t state_ff;
	sync_state_t nxt_state;

	// The first stage feeds the second stage only.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_state.stage1 = async_in;
		nxt_state.stage2 = state_ff.stage1;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
			state_ff <= '0;
		else
			state_ff <= nxt_state;
	end

	assign sync_out = state_ff.stage2;

endmodule : pin_sync

// file: verification/timer_pins_model.sv
// Model of the pins around the timer: external clocks, slow clock, lines.
`timescale 1ns/1ps
module timer_pins_model (
	input wire logic clk_sys,
	output logic [2:0] ext_clock_pin,
	output logic slow_clk_pin,
	output logic [2:0] line_a_drv,
	output logic [2:0] line_b_drv
);
	initial
	begin
		ext_clock_pin = 3'h0;
		slow_clk_pin = 1'b0;
		line_a_drv = 3'h0;
		line_b_drv = 3'h0;
	end

	////////////////////////////////////////////////////////////////////////
	// The slow clock runs free; the external pins stand still between bursts.
	always
	begin
		repeat (8) @(posedge clk_sys);
		slow_clk_pin <= ~slow_clk_pin;
	end

	// The high level lasts three cycles and the low level four, so the rate stays well below 1/2.5.
	task clk_pulses(input int pin, input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			ext_clock_pin <= 3'h1 << pin;
			repeat (3) @(posedge clk_sys);
			ext_clock_pin <= 3'h0;
			repeat (3) @(posedge clk_sys);
		end
		repeat (4) @(posedge clk_sys);
	endtask : clk_pulses

	// Index 0..2 pulses line A of a channel, 3..5 line B.
	task line_pulse(input int idx);
		@(posedge clk_sys);
		{line_b_drv, line_a_drv} <= 6'h1 << idx;
		repeat (4) @(posedge clk_sys);
		{line_b_drv, line_a_drv} <= 6'h0;
		repeat (5) @(posedge clk_sys);
	endtask : line_pulse
endmodule : timer_pins_model

// file: verification/timer_block_props.sv
// Checker of the timer block's bus and pin behaviour at its ports.
`timescale 1ns/1ps
module timer_block_props (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [2:0] ext_clock_pin,
	input wire logic slow_clk_pin,
	input wire logic [2:0] line_a_in,
	input wire logic [2:0] line_a_out,
	input wire logic [2:0] line_a_oe,
	input wire logic [2:0] line_b_in,
	input wire logic [2:0] line_b_out,
	input wire logic [2:0] line_b_oe
);
	logic mode_wr;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	assign mode_wr = avs_write && !avs_waitrequest &&
		avs_address[5:0] == timer_pkg::OFS_CHANNEL_MODE &&
		avs_address[7:6] != timer_pkg::SEL_BLOCK;

	////////////////////////////////////////////////////////////////////////
	first_wait_a: assert property ($rose(avs_read || avs_write) |->
		avs_waitrequest ##1 !avs_waitrequest)
		else $error("request not answered after one wait cycle");
	idle_no_wait_a: assert property (!(avs_read || avs_write) |->
		!avs_waitrequest) else $error("wait raised without a request");
	rdata_hold_a: assert property (!(avs_read || avs_write) |=>
		$stable(avs_readdata)) else $error("read data moved while idle");
	unmapped_zero_a: assert property (avs_read && !avs_waitrequest &&
		avs_address[5:0] == 6'h3c |-> avs_readdata == 32'h0)
		else $error("unmapped word read nonzero");
	reset_quiet_a: assert property ($rose(rst_n) |->
		line_a_oe == 3'h0 && line_b_oe == 3'h0 && avs_readdata == 32'h0)
		else $error("outputs not quiet after reset");
	oe_line_a_a: assert property (mode_wr |=>
		line_a_oe[$past(avs_address[7:6])] == $past(avs_writedata[15]))
		else $error("line A direction does not follow mode");
	oe_line_b_a: assert property (mode_wr |=>
		line_b_oe[$past(avs_address[7:6])] == ($past(avs_writedata[15]) &&
		$past(avs_writedata[21:20]) != 2'h0))
		else $error("line B direction does not follow mode");
	out_low_a: assert property (line_a_out == 3'h0 && line_b_out == 3'h0)
		else $error("line output driven high");
endmodule : timer_block_props

bind timer_block timer_block_props props_u (.clk_sys, .rst_n, .avs_address,
	.avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
	.ext_clock_pin, .slow_clk_pin, .line_a_in, .line_a_out, .line_a_oe,
	.line_b_in, .line_b_out, .line_b_oe);

// file: verification/timer_block_tb_top.sv
// Self-checking testbench of the three-channel timer block.
`timescale 1ns/1ps
module timer_block_tb_top;
	localparam logic [5:0] o_ctl = timer_pkg::OFS_CHANNEL_CONTROL;
	localparam logic [5:0] o_mode = timer_pkg::OFS_CHANNEL_MODE;
	localparam logic [5:0] o_cv = timer_pkg::OFS_COUNTER_VALUE;
	localparam logic [5:0] o_st = timer_pkg::OFS_CHANNEL_STATUS;
	localparam logic [1:0] blk = timer_pkg::SEL_BLOCK;
	logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, slow_clk_pin;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [2:0] ext_clock_pin, line_a_in, line_a_out, line_a_oe, line_a_drv;
	logic [2:0] line_b_in, line_b_out, line_b_oe, line_b_drv;
	int error_cnt, cmp_count;
	logic [31:0] trg_mode [4] = '{32'h505, 32'h205, 32'h705, 32'h405};
	int trg_line [4] = '{1, 4, 1, 1};
	logic [31:0] trg_exp [4] = '{32'h0, 32'h0, 32'h0, 32'h3};

	// Pins with output enable set (line A in waveform mode, line B too unless it is the event source) are driven by the block, otherwise by the model.
	assign line_a_in = (line_a_oe & line_a_out) | (~line_a_oe & line_a_drv);
	assign line_b_in = (line_b_oe & line_b_out) | (~line_b_oe & line_b_drv);

	timer_block dut_u (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .ext_clock_pin,
		.slow_clk_pin, .line_a_in, .line_a_out, .line_a_oe, .line_b_in,
		.line_b_out, .line_b_oe);
	timer_pins_model pins_u (.clk_sys, .ext_clock_pin, .slow_clk_pin,
		.line_a_drv, .line_b_drv);

	////////////////////////////////////////////////////////////////////////
	function logic [7:0] ad(input logic [1:0] c, input logic [5:0] o);
		return {c, o};
	endfunction : ad

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask : rdc

	task stop_test();
		$display("comparisons %0d, mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// Whole run is under a thousand cycles; this bound only catches a hang.
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		error_cnt++;
		stop_test();
	end

	initial
	begin
		rst_n = 1'b0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_address = 8'h00;
		avs_writedata = 32'h0;
		error_cnt = 0;
		cmp_count = 0;
		repeat (4) @(posedge clk_sys);
		rst_n <= 1'b1;
		rdc(ad(0, o_cv), 32'h0);
		rdc(ad(0, o_st), 32'h0);
		rdc(ad(0, o_mode), 32'h0);
		rdc(ad(blk, timer_pkg::OFS_BLOCK_MODE), 32'h0);
		rdc(ad(0, 6'h3c), 32'h0);
		$display("reset test done");
		wr(ad(0, o_mode), 32'h5);
		rdc(ad(0, o_mode), 32'h5);
		wr(ad(0, o_ctl), 32'h1);
		rdc(ad(0, o_st), 32'h1_0000);
		pins_u.clk_pulses(0, 3);
		rdc(ad(0, o_cv), 32'h0);
		wr(ad(0, o_ctl), 32'h4);
		pins_u.clk_pulses(0, 5);
		rdc(ad(0, o_cv), 32'h4);
		wr(ad(0, o_mode), 32'h25);
		pins_u.clk_pulses(0, 2);
		rdc(ad(0, o_cv), 32'h4);
		wr(ad(0, o_mode), 32'h5);
		wr(ad(0, o_ctl), 32'h2);
		rdc(ad(0, o_st), 32'h0);
		wr(ad(0, o_ctl), 32'h4);
		pins_u.clk_pulses(0, 2);
		rdc(ad(0, o_cv), 32'h4);
		wr(ad(0, o_ctl), 32'h3);
		rdc(ad(0, o_st), 32'h0);
		$display("clock control test done");
		wr(ad(0, o_mode), 32'h0005_0045);
		wr(ad(0, o_ctl), 32'h1);
		wr(ad(0, o_ctl), 32'h4);
		pins_u.clk_pulses(0, 2);
		pins_u.line_pulse(0);
		pins_u.clk_pulses(0, 1);
		pins_u.line_pulse(0);
		pins_u.clk_pulses(0, 1);
		rdc(ad(0, o_cv), 32'h2);
		rdc(ad(0, timer_pkg::OFS_CAPTURE_A), 32'h1);
		rdc(ad(0, timer_pkg::OFS_CAPTURE_B), 32'h2);
		rdc(ad(0, o_st), 32'h1_0000);
		wr(ad(0, o_mode), 32'h0005_00c5);
		wr(ad(0, o_ctl), 32'h4);
		pins_u.clk_pulses(0, 1);
		pins_u.line_pulse(0);
		pins_u.line_pulse(0);
		rdc(ad(0, o_st), 32'h0);
		wr(ad(0, o_ctl), 32'h1);
		wr(ad(0, o_ctl), 32'h4);
		pins_u.line_pulse(0);
		rdc(ad(0, o_st), 32'h1_0002);
		rdc(ad(0, o_st), 32'h1_0000);
		wr(ad(0, o_mode), 32'hd);
		wr(ad(0, o_ctl), 32'h4);
		pins_u.clk_pulses(0, 1);
		// An inverted clock must not count on the pin's rising edge.
		fork
			pins_u.clk_pulses(0, 1);
			begin
				repeat (4) @(posedge clk_sys);
				rdc(ad(0, o_cv), 32'h0);
			end
		join
		rdc(ad(0, o_cv), 32'h1);
		$display("capture test done");
		wr(ad(1, o_mode), 32'h7);
		wr(ad(2, o_mode), 32'h6);
		wr(ad(1, o_ctl), 32'h1);
		wr(ad(2, o_ctl), 32'h1);
		pins_u.clk_pulses(2, 2);
		rdc(ad(1, o_cv), 32'h0);
		wr(ad(blk, timer_pkg::OFS_BLOCK_CONTROL), 32'h1);
		pins_u.clk_pulses(2, 3);
		pins_u.clk_pulses(1, 3);
		rdc(ad(1, o_cv), 32'h2);
		rdc(ad(2, o_cv), 32'h2);
		$display("sync test done");
		for (int i = 0; i < 4; i++)
		begin
			wr(ad(1, o_mode), trg_mode[i]);
			wr(ad(1, o_ctl), 32'h4);
			pins_u.clk_pulses(0, 3);
			pins_u.line_pulse(trg_line[i]);
			pins_u.clk_pulses(0, 1);
			rdc(ad(1, o_cv), trg_exp[i]);
		end
		$display("external trigger test done");
		wr(ad(1, timer_pkg::OFS_COMPARE_C), 32'h2);
		rdc(ad(1, timer_pkg::OFS_COMPARE_C), 32'h2);
		wr(ad(1, o_mode), 32'h4005);
		wr(ad(1, o_ctl), 32'h4);
		pins_u.clk_pulses(0, 6);
		rdc(ad(1, o_cv), 32'h1);
		$display("compare trigger test done");
		wr(ad(blk, timer_pkg::OFS_BLOCK_MODE), 32'h10);
		rdc(ad(blk, timer_pkg::OFS_BLOCK_MODE), 32'h10);
		wr(ad(2, o_mode), 32'h7);
		wr(ad(2, o_ctl), 32'h4);
		repeat (3) pins_u.line_pulse(0);
		rdc(ad(2, o_cv), 32'h2);
		$display("chaining test done");
		wr(ad(2, o_mode), 32'h8000);
		@(negedge clk_sys);
		chk({29'h0, line_a_oe}, 32'h4);
		chk({29'h0, line_b_oe}, 32'h0);
		wr(ad(2, o_mode), 32'h0010_8000);
		@(negedge clk_sys);
		chk({29'h0, line_b_oe}, 32'h4);
		$display("direction test done");
		stop_test();
	end
endmodule : timer_block_tb_top
